//--- shared/pls_synth_map.vh
`ifndef PLS_SYNTH_MAP_VH
`define PLS_SYNTH_MAP_VH

// Serial word and mode addresses, address bits taken first bit in as LSB.
`define PLS_ADDR_IN1 8'h28
`define PLS_ADDR_IN2 8'h29
`define PLS_ADDR_OUT 8'h2a
`define PLS_WORD_BITS 5'h18

// First word fields.
`define PLS_W1_DIV_MSB 15
`define PLS_W1_SNS 16
`define PLS_W1_DVS 17
`define PLS_W1_CTE 18
`define PLS_W1_XS 19
`define PLS_W1_REF_LSB 20

// Second word fields.
`define PLS_W2_IODIR_LSB 0
`define PLS_W2_PORT_LSB 2
`define PLS_W2_DOC_LSB 8
`define PLS_W2_UL_LSB 11
`define PLS_W2_DZ_LSB 13
`define PLS_W2_GT_LSB 15

// Reset values.
`define PLS_RST_DIVISOR 16'h0110
`define PLS_RST_REF 4'hf
`define PLS_RST_DOC 3'h0

// Output pin functions.
`define PLS_DOC_UNLOCK 3'h1
`define PLS_DOC_DONE 3'h2
`define PLS_DOC_IO1 3'h5
`define PLS_DOC_IO2 3'h6

// Timing in milliseconds, reference period in clock cycles, and clock rate.
`define PLS_CLK_HZ 40000000
`define PLS_GATE_MS_0 7'h04
`define PLS_GATE_MS_1 7'h08
`define PLS_GATE_MS_2 7'h20
`define PLS_GATE_MS_3 7'h40
`define PLS_WAIT_MS_SHORT 7'h04
`define PLS_WAIT_MS_LONG 7'h08
`define PLS_REF_CYCLES 400

`endif

//--- hdl/pls_synth_ctrl.v
`include "pls_synth_map.vh"

module pls_synth_ctrl #(
	parameter CLK_PER_MS = `PLS_CLK_HZ / 1000,
	parameter REF_CYCLES = `PLS_REF_CYCLES
) (
	input wire clk,
	input wire rst_n,
	input wire chipSelect,
	input wire serial_clock_pin,
	input wire serialDataIn,
	input wire fm_divider_input,
	input wire am_divider_input,
	input wire if_count_input,
	input wire ioPin1,
	input wire ioPin2,
	input wire phaseErrorWide,
	output reg dataOut,
	output reg dataOutOe,
	output reg dividerPulse,
	output reg refTick,
	output reg [3:0] ref_freq_select,
	output reg crystalSelect,
	output reg [1:0] ioDirection,
	output reg [5:0] portData,
	output reg [1:0] deadZoneMode,
	output reg chargePumpOnOn,
	output reg lockedNow,
	output reg countDone
);

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
// A pin level changes only once the second and third stages agree.
reg [8:0] sync1;
reg [8:0] sync2;
reg [8:0] sync3;
reg [8:0] pinLvl;
reg [8:0] pinPrev;
wire [8:0] pinRise = pinLvl & ~pinPrev;
wire [8:0] pinFall = ~pinLvl & pinPrev;

always @(posedge clk) begin
	if (!rst_n) begin
		sync1 <= 9'h000;
		sync2 <= 9'h000;
		sync3 <= 9'h000;
		pinLvl <= 9'h000;
		pinPrev <= 9'h000;
	end else begin
		sync1 <= {phaseErrorWide, ioPin2, ioPin1, if_count_input, am_divider_input,
			fm_divider_input, serialDataIn, serial_clock_pin, chipSelect};
		sync2 <= sync1;
		sync3 <= sync2;
		pinLvl <= (sync2 & sync3) | (pinLvl & (sync2 ^ sync3));
		pinPrev <= pinLvl;
	end
end

wire ceRise = pinRise[0];
wire ceFall = pinFall[0];
wire ceHigh = pinLvl[0];
wire clRise = pinRise[1];
wire clFall = pinFall[1];
wire diLvl = pinLvl[2];

// ----------------------------------------------------------------
// Serial receive and active latches
// ----------------------------------------------------------------
localparam MD_NONE = 2'd0;
localparam MD_IN1 = 2'd1;
localparam MD_IN2 = 2'd2;
localparam MD_OUT = 2'd3;

reg [7:0] addrShift;
reg [1:0] mode;
reg [23:0] inShift;
reg [4:0] bitCnt;
reg [23:0] outShift;
reg [15:0] divisor_bits;
reg divider_input_select;
reg am_speed_select;
reg if_count_run;
reg [2:0] out_pin_function_sel;
reg [1:0] unlockDetWidth;
reg [1:0] gateSel;
reg unlockSticky;
reg unlockEval;
reg [19:0] if_count_value;
reg [1:0] next_mode;

always @* begin
	case (addrShift)
		`PLS_ADDR_IN1: next_mode = MD_IN1;
		`PLS_ADDR_IN2: next_mode = MD_IN2;
		`PLS_ADDR_OUT: next_mode = MD_OUT;
		default: next_mode = MD_NONE;
	endcase
end

// Stopped detection reads as locked.
wire unlock_flag = ~(unlockSticky & (unlockDetWidth != 2'b00));
wire wordFull = (bitCnt == `PLS_WORD_BITS);

always @(posedge clk) begin
	if (!rst_n) begin
		addrShift <= 8'h00;
		mode <= MD_NONE;
		inShift <= 24'h000000;
		bitCnt <= 5'h00;
		outShift <= 24'h000000;
		divisor_bits <= `PLS_RST_DIVISOR;
		divider_input_select <= 1'b0;
		am_speed_select <= 1'b0;
		if_count_run <= 1'b0;
		crystalSelect <= 1'b0;
		ref_freq_select <= `PLS_RST_REF;
		ioDirection <= 2'b00;
		portData <= 6'h00;
		out_pin_function_sel <= `PLS_RST_DOC;
		unlockDetWidth <= 2'b00;
		deadZoneMode <= 2'b00;
		chargePumpOnOn <= 1'b1;
		gateSel <= 2'b00;
	end else begin
		if (!ceHigh && clRise) begin
			addrShift <= {diLvl, addrShift[7:1]};
		end
		if (ceRise) begin
			mode <= next_mode;
			bitCnt <= 5'h00;
			// Output word, first bit out is the top: I2, I1, flag, spare, count.
			outShift <= {pinLvl[7], pinLvl[6], unlock_flag, 1'b0, if_count_value};
		end else if (ceHigh && clRise && (mode == MD_IN1 || mode == MD_IN2)) begin
			inShift <= {diLvl, inShift[23:1]};
			if (!wordFull) begin
				bitCnt <= bitCnt + 5'd1;
			end
		end else if (ceHigh && clFall && mode == MD_OUT) begin
			// Each clock moves one bit; clocks past the word return zero.
			outShift <= {outShift[22:0], 1'b0};
		end
		if (ceFall) begin
			mode <= MD_NONE;
			if (mode == MD_IN1 && wordFull) begin
				divisor_bits <= inShift[`PLS_W1_DIV_MSB:0];
				am_speed_select <= inShift[`PLS_W1_SNS];
				divider_input_select <= inShift[`PLS_W1_DVS];
				if_count_run <= inShift[`PLS_W1_CTE];
				crystalSelect <= inShift[`PLS_W1_XS];
				ref_freq_select <= inShift[`PLS_W1_REF_LSB +: 4];
			end
			if (mode == MD_IN2 && wordFull) begin
				ioDirection <= inShift[`PLS_W2_IODIR_LSB +: 2];
				portData <= inShift[`PLS_W2_PORT_LSB +: 6];
				out_pin_function_sel <= inShift[`PLS_W2_DOC_LSB +: 3];
				unlockDetWidth <= inShift[`PLS_W2_UL_LSB +: 2];
				deadZoneMode <= inShift[`PLS_W2_DZ_LSB +: 2];
				chargePumpOnOn <= ~inShift[`PLS_W2_DZ_LSB + 1];
				gateSel <= inShift[`PLS_W2_GT_LSB +: 2];
			end
		end
	end
end

// ----------------------------------------------------------------
// Programmable divider
// ----------------------------------------------------------------
reg prescale;
reg [15:0] divCnt;
// Slow AM mode drops the four low bits of the divisor.
wire [15:0] divLoad = (divider_input_select | am_speed_select) ? divisor_bits :
	{4'h0, divisor_bits[15:4]};
wire divEvt = divider_input_select ? (pinRise[3] & prescale) : pinRise[4];

always @(posedge clk) begin
	if (!rst_n) begin
		prescale <= 1'b0;
		divCnt <= 16'h0000;
		dividerPulse <= 1'b0;
	end else begin
		if (pinRise[3]) begin
			prescale <= ~prescale;
		end
		dividerPulse <= 1'b0;
		if (divEvt) begin
			if (divCnt <= 16'h0001) begin
				divCnt <= divLoad;
				dividerPulse <= 1'b1;
			end else begin
				divCnt <= divCnt - 16'h0001;
			end
		end
	end
end

// ----------------------------------------------------------------
// IF counter
// ----------------------------------------------------------------
localparam IF_IDLE = 2'd0;
localparam IF_WAIT = 2'd1;
localparam IF_GATE = 2'd2;
localparam IF_DONE = 2'd3;

function [21:0] msToCycles;
	input [6:0] ms;
	reg [31:0] full;
	begin
		full = ms * CLK_PER_MS;
		msToCycles = full[21:0];
	end
endfunction

reg [1:0] ifState;
reg [21:0] ifTimer;
reg runPrev;
wire [6:0] gateMs = (gateSel == 2'd0) ? `PLS_GATE_MS_0 : (gateSel == 2'd1) ? `PLS_GATE_MS_1 :
	(gateSel == 2'd2) ? `PLS_GATE_MS_2 : `PLS_GATE_MS_3;
wire [6:0] waitMs = gateSel[1] ? `PLS_WAIT_MS_LONG : `PLS_WAIT_MS_SHORT;

always @(posedge clk) begin
	if (!rst_n) begin
		ifState <= IF_IDLE;
		ifTimer <= 22'h000000;
		runPrev <= 1'b0;
		if_count_value <= 20'h00000;
		countDone <= 1'b0;
	end else begin
		runPrev <= if_count_run;
		if (!if_count_run) begin
			ifState <= IF_IDLE;
			if_count_value <= 20'h00000;
			countDone <= 1'b0;
		end else begin
			case (ifState)
				IF_IDLE: begin
					if (!runPrev) begin
						ifState <= IF_WAIT;
						ifTimer <= msToCycles(waitMs);
					end
				end
				IF_WAIT: begin
					if (ifTimer <= 22'h000001) begin
						ifState <= IF_GATE;
						ifTimer <= msToCycles(gateMs);
					end else begin
						ifTimer <= ifTimer - 22'h000001;
					end
				end
				IF_GATE: begin
					if (pinRise[5]) begin
						if_count_value <= if_count_value + 20'h00001;
					end
					if (ifTimer <= 22'h000001) begin
						ifState <= IF_DONE;
						countDone <= 1'b1;
					end else begin
						ifTimer <= ifTimer - 22'h000001;
					end
				end
				default: ifState <= IF_DONE;
			endcase
		end
	end
end

// ----------------------------------------------------------------
// Unlock detection
// ----------------------------------------------------------------
// A phase error seen anywhere in one reference period marks the period
// unlocked, so a decision never comes sooner than one period.
reg [15:0] refCnt;
reg errSeen;

always @(posedge clk) begin
	if (!rst_n) begin
		refCnt <= 16'h0000;
		refTick <= 1'b0;
		errSeen <= 1'b0;
		unlockEval <= 1'b0;
		unlockSticky <= 1'b0;
		lockedNow <= 1'b1;
	end else begin
		refTick <= 1'b0;
		if (refCnt >= REF_CYCLES[15:0] - 16'h0001) begin
			refCnt <= 16'h0000;
			refTick <= 1'b1;
			unlockEval <= errSeen | pinLvl[8];
			lockedNow <= ~(errSeen | pinLvl[8]) | (unlockDetWidth == 2'b00);
			errSeen <= 1'b0;
		end else begin
			refCnt <= refCnt + 16'h0001;
			errSeen <= errSeen | pinLvl[8];
		end
		// A fresh unlock in the clearing cycle still wins.
		if (refTick && unlockEval) begin
			unlockSticky <= 1'b1;
		end else if (ceFall && mode != MD_NONE) begin
			unlockSticky <= 1'b0;
		end
	end
end

// ----------------------------------------------------------------
// Data output pin
// ----------------------------------------------------------------
reg doneShown;
reg next_oe;

always @* begin
	next_oe = 1'b0;
	if (ceHigh) begin
		if (mode == MD_OUT) begin
			next_oe = ~outShift[23];
		end
	end else begin
		case (out_pin_function_sel)
			`PLS_DOC_UNLOCK: next_oe = ~lockedNow;
			`PLS_DOC_DONE: next_oe = doneShown;
			`PLS_DOC_IO1: next_oe = ~pinLvl[6];
			`PLS_DOC_IO2: next_oe = ~pinLvl[7];
			default: next_oe = 1'b0;
		endcase
	end
end

always @(posedge clk) begin
	if (!rst_n) begin
		doneShown <= 1'b0;
		dataOut <= 1'b0;
		dataOutOe <= 1'b0;
	end else begin
		// Shown from completion until the strobe next rises.
		// Completion wins over a clear that falls in the same cycle.
		if (ifState == IF_GATE && ifTimer <= 22'h000001 && if_count_run) begin
			doneShown <= 1'b1;
		end else if (ceRise || (if_count_run && !runPrev)) begin
			doneShown <= 1'b0;
		end
		dataOut <= 1'b0;
		dataOutOe <= next_oe;
	end
end

endmodule

//--- bench/pls_synth_checker_assertions.sv
module pls_synth_checker #(
	parameter REF_CYCLES = 400
) (
	input wire clk,
	input wire rst_n,
	input wire chipSelect,
	input wire phaseErrorWide,
	input wire dataOut,
	input wire dividerPulse,
	input wire refTick,
	input wire [3:0] ref_freq_select,
	input wire crystalSelect,
	input wire [1:0] ioDirection,
	input wire [5:0] portData,
	input wire [1:0] deadZoneMode,
	input wire chargePumpOnOn,
	input wire lockedNow,
	input wire countDone
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------
	// Helper counters.
	// ------
	int tickGap;
	int lowAge;
	int errAge;
	logic tickSeen;
	always @(posedge clk) begin
		if (!rst_n) begin
			tickGap <= 0;
			tickSeen <= 1'b0;
			lowAge <= 0;
			errAge <= 1000;
		end else begin
			tickGap <= refTick ? 0 : tickGap + 1;
			tickSeen <= tickSeen | refTick;
			lowAge <= chipSelect ? 0 : (lowAge < 100 ? lowAge + 1 : lowAge);
			errAge <= phaseErrorWide ? 0 : (errAge < 1000 ? errAge + 1 : errAge);
		end
	end
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence quietGap;
		!dividerPulse [*4];
	endsequence
	pump_mode_a: assert property (chargePumpOnOn == !deadZoneMode[1])
		else $error("charge pump mode does not follow dead zone code");
	ref_period_a: assert property (refTick && tickSeen |-> tickGap == REF_CYCLES - 1)
		else $error("reference tick spacing wrong");
	lock_step_a: assert property ($changed(lockedNow) |-> refTick || $past(refTick))
		else $error("lock state moved between reference ticks");
	field_latch_a: assert property ($changed({ref_freq_select, crystalSelect, ioDirection,
		portData, deadZoneMode}) |-> !chipSelect && lowAge <= 10)
		else $error("latched fields moved away from strobe fall");
	drain_zero_a: assert property (dataOut == 1'b0)
		else $error("open drain data level not low");
	done_clear_a: assert property ($fell(countDone) |-> !chipSelect && lowAge <= 10)
		else $error("count done cleared without a new word");
	div_gap_a: assert property (dividerPulse |=> quietGap)
		else $error("divider pulses too close");
	unlock_cause_a: assert property ($fell(lockedNow) |-> errAge <= 2 * REF_CYCLES + 8)
		else $error("unlock without recent phase error");
endmodule

bind pls_synth_ctrl pls_synth_checker #(.REF_CYCLES(REF_CYCLES)) chk_i (
	.clk(clk),
	.rst_n(rst_n),
	.chipSelect(chipSelect),
	.phaseErrorWide(phaseErrorWide),
	.dataOut(dataOut),
	.dividerPulse(dividerPulse),
	.refTick(refTick),
	.ref_freq_select(ref_freq_select),
	.crystalSelect(crystalSelect),
	.ioDirection(ioDirection),
	.portData(portData),
	.deadZoneMode(deadZoneMode),
	.chargePumpOnOn(chargePumpOnOn),
	.lockedNow(lockedNow),
	.countDone(countDone)
);

//--- bench/pls_host_model.sv
module pls_host_model (
	input wire clk,
	input wire dataOutOe,
	output logic chipSelect,
	output logic serial_clock_pin,
	output logic serialDataIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------
	// Serial link master.
	// ------
	initial begin
		chipSelect = 1'b0;
		serial_clock_pin = 1'b0;
		serialDataIn = 1'b0;
	end
	// The returned bit is the pulled-up line level, sampled just before the clock falls.
	// The block moves its output some six clocks after a fall, so the level taken a
	// full link period later is settled.
	task bitClk(input logic d, output logic q);
		serialDataIn = d;
		repeat (4) @(negedge clk);
		serial_clock_pin = 1'b1;
		repeat (4) @(negedge clk);
		q = ~dataOutOe;
		serial_clock_pin = 1'b0;
	endtask
	task xfer(input logic [7:0] addr, input int n, input logic [23:0] d, output logic [23:0] q);
		logic s;
		@(negedge clk);
		for (int i = 0; i < 8; i++)
			bitClk(addr[i], s);
		chipSelect = 1'b1;
		for (int i = 0; i < n; i++) begin
			bitClk(d[i], s);
			q[23 - i] = s;
		end
		serialDataIn = ~serialDataIn;
		repeat (4) @(negedge clk);
		chipSelect = 1'b0;
		repeat (8) @(negedge clk);
	endtask
endmodule

//--- bench/test_pls_synth_ctrl.sv
`include "pls_synth_map.vh"
`define CHK(w, e, g) begin \
	tests_run++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("[FAIL] %s exp %0h got %0h", w, e, g); \
	end \
end
module test_pls_synth_ctrl;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0;
	logic rst_n = 0;
	logic gen = 0;
	logic ioPin1 = 1;
	logic ioPin2 = 0;
	logic phaseErrorWide = 0;
	wire chipSelect, serial_clock_pin, serialDataIn, dataOut, dataOutOe, dividerPulse, refTick;
	wire crystalSelect, chargePumpOnOn, lockedNow, countDone;
	wire [3:0] ref_freq_select;
	wire [1:0] ioDirection, deadZoneMode;
	wire [5:0] portData;
	int n_errors = 0;
	int tests_run = 0;
	int ph = 0;
	int edges = 0;
	int lastAt = 0;
	int lastGap = 0;
	int gc[4] = '{20, 40, 160, 320};
	logic [23:0] rd;
	// ------
	// Clock, pulse source and harness.
	// ------
	initial begin
		forever #12.5 clk = ~clk;
	end
	// One rising edge every 8 clocks feeds all three counted inputs.
	always @(negedge clk) begin
		ph <= ph + 1;
		if (ph % 4 == 3) begin
			gen <= ~gen;
			if (!gen)
				edges <= edges + 1;
		end
	end
	always @(posedge clk) begin
		if (dividerPulse) begin
			lastGap <= edges - lastAt;
			lastAt <= edges;
		end
	end
	pls_host_model pls_host_model_i (
		.clk(clk),
		.dataOutOe(dataOutOe),
		.chipSelect(chipSelect),
		.serial_clock_pin(serial_clock_pin),
		.serialDataIn(serialDataIn)
	);
	pls_synth_ctrl #(.CLK_PER_MS(40), .REF_CYCLES(20)) pls_synth_ctrl_i (
		.clk(clk),
		.rst_n(rst_n),
		.chipSelect(chipSelect),
		.serial_clock_pin(serial_clock_pin),
		.serialDataIn(serialDataIn),
		.fm_divider_input(gen),
		.am_divider_input(gen),
		.if_count_input(gen),
		.ioPin1(ioPin1),
		.ioPin2(ioPin2),
		.phaseErrorWide(phaseErrorWide),
		.dataOut(dataOut),
		.dataOutOe(dataOutOe),
		.dividerPulse(dividerPulse),
		.refTick(refTick),
		.ref_freq_select(ref_freq_select),
		.crystalSelect(crystalSelect),
		.ioDirection(ioDirection),
		.portData(portData),
		.deadZoneMode(deadZoneMode),
		.chargePumpOnOn(chargePumpOnOn),
		.lockedNow(lockedNow),
		.countDone(countDone)
	);
	task end_sim;
		$display("Counts: %0d checks, %0d mismatches", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task waitSig(input bit pick, input int lim);
		int k;
		k = 0;
		while ((pick ? countDone : dividerPulse) !== 1'b1) begin
			@(negedge clk);
			k++;
			if (k > lim) begin
				n_errors++;
				$display("[FAIL] wait exp 1 got timeout");
				end_sim;
			end
		end
		@(negedge clk);
	endtask
	task xf(input logic [7:0] a, input logic [23:0] d);
		pls_host_model_i.xfer(a, 24, d, rd);
	endtask
	// ------
	// Main sequence.
	// ------
	initial begin
		wt(2);
		rst_n = 1'b1;
		wt(4);
		`CHK("refSel", 4'hf, ref_freq_select)
		`CHK("pump", 1'b1, chargePumpOnOn)
		for (int z = 0; z < 4; z++) begin
			xf(`PLS_ADDR_IN2, {9'h0, z[1:0], 13'h0});
			`CHK("dz", z[1:0], deadZoneMode)
			`CHK("pump", ~z[1], chargePumpOnOn)
		end
		xf(`PLS_ADDR_IN1, {4'h5, 4'b1000, 16'h0005});
		`CHK("refSel", 4'h5, ref_freq_select)
		pls_host_model_i.xfer(`PLS_ADDR_IN1, 20, 24'h0, rd);
		`CHK("shortWord", 1'b1, crystalSelect)
		$display("end of test: latches");
		for (int m = 0; m < 3; m++) begin
			xf(`PLS_ADDR_IN1, {4'h5, 2'b10, m == 0, m == 1, m == 2 ? 16'h005f : 16'h0005});
			repeat (3) waitSig(0, 5000);
			`CHK("divGap", m == 0 ? 10 : 5, lastGap)
		end
		$display("end of test: divider");
		for (int g = 0; g < 4; g++) begin
			xf(`PLS_ADDR_IN2, {7'h0, g[1:0], 2'b00, 2'b01, 3'h2, 6'h2a, 2'b01});
			`CHK("port", 6'h2a, portData)
			`CHK("ioDir", 2'b01, ioDirection)
			xf(`PLS_ADDR_IN1, {4'h5, 4'b1000, 16'h0005});
			xf(`PLS_ADDR_IN1, {4'h5, 4'b1100, 16'h0005});
			`CHK("oeRun", 1'b0, dataOutOe)
			waitSig(1, 4000);
			`CHK("oeDone", 1'b1, dataOutOe)
			xf(`PLS_ADDR_OUT, 24'h0);
			`CHK("count", gc[g][19:0], rd[19:0])
			`CHK("head", 3'b011, rd[23:21])
		end
		xf(`PLS_ADDR_IN1, {4'h5, 4'b1000, 16'h0005});
		`CHK("done", 1'b0, countDone)
		xf(`PLS_ADDR_OUT, 24'h0);
		`CHK("cleared", 20'h0, rd[19:0])
		$display("end of test: if counter");
		xf(`PLS_ADDR_IN2, {11'h0, 2'b01, 3'h1, 8'h0});
		phaseErrorWide = 1'b1;
		wt(80);
		`CHK("lock", 1'b0, lockedNow)
		`CHK("oeLock", 1'b1, dataOutOe)
		phaseErrorWide = 1'b0;
		wt(80);
		`CHK("lock", 1'b1, lockedNow)
		`CHK("oeLock", 1'b0, dataOutOe)
		xf(`PLS_ADDR_OUT, 24'h0);
		`CHK("ulSticky", 1'b0, rd[21])
		xf(`PLS_ADDR_OUT, 24'h0);
		`CHK("ulSecond", 1'b1, rd[21])
		$display("end of test: unlock");
		xf(`PLS_ADDR_IN2, {13'h0, 3'h5, 8'h0});
		for (int v = 0; v < 2; v++) begin
			ioPin1 = v[0];
			wt(8);
			`CHK("ioPin", ~v[0], dataOutOe)
		end
		$display("end of test: pin function");
		end_sim;
	end
endmodule
